//--- hw/byte_buffer.sv
/*
  small valid/ready buffer with flush; input ready is a register.
  assumes flush has priority over a push in the same cycle.
*/
`timescale 1ns/1ps

module byte_buffer #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_flush,
  byte_stream_if.snk in_s,
  byte_stream_if.src out_s,
  output logic [$clog2(DEPTH+1)-1:0] o_count
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("byte_buffer depth must be a power of two of at least 2");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic rdy_q, rdy_d;
  logic push, pop;

  always_comb begin
    push = in_s.valid && rdy_q;
    pop = out_s.ready && (cnt_q != '0);
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (i_flush) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end else begin
      if (push) begin
        mem_d[wr_q] = in_s.data;
        wr_d = PW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_d = PW'(rd_q + 1'b1);
      end
      cnt_d = CW'(cnt_q + CW'(push) - CW'(pop));
    end
    rdy_d = (cnt_d < CW'(DEPTH));
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    mem_q <= mem_d;
  end

  assign in_s.ready = rdy_q;
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data = mem_q[rd_q];
  assign o_count = cnt_q;
endmodule : byte_buffer

//--- hw/byte_stream_if.sv
/*
  valid/ready stream carrier between the engine and its byte buffer.
  assumes one clock shared by both ends.
*/
`timescale 1ns/1ps

interface byte_stream_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

//--- hw/fast_read_pkg.sv
/*
  types of the fast read engine: frame states and lane widths.
  assumes nothing of its surroundings.
*/
package fast_read_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPC,
    ST_ADDR,
    ST_MODE,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } rd_state_t;

  typedef enum logic [1:0] {
    LANE_1,
    LANE_2,
    LANE_4
  } lane_t;

endpackage : fast_read_pkg

//--- hw/fast_read_regs.svh
/*
  fast read engine constants: opcodes, phase lengths and dummy clock counts.
  assumes inclusion by bare name from the design files.
*/
`ifndef FAST_READ_REGS_SVH
`define FAST_READ_REGS_SVH

// opcodes of the multi-line reads and the enhance-mode exit byte
`define OPC_DUAL_OUT 8'h3B
`define OPC_DUAL_IO 8'hBB
`define OPC_QUAD_OUT 8'h6B
`define OPC_QUAD_IO 8'hEB
`define OPC_ENH_EXIT 8'hFF

// phase lengths in bits and clocks
`define OPC_BITS 6'h08
`define MODE_BITS 6'h08
`define MODE_CLKS 4'h2
`define DUMMY_OUT_CLKS 4'h8
`define DUMMY_DUAL_IO_CLKS 4'h4

// dummy length field codes and the quad clock counts they select
`define DLEN_3BYTE 2'h0
`define DLEN_2BYTE 2'h1
`define DLEN_4BYTE 2'h2
`define DLEN_5BYTE 2'h3
`define DLEN_RESET 2'h0
`define DUMMY_Q_2BYTE 4'h4
`define DUMMY_Q_3BYTE 4'h6
`define DUMMY_Q_4BYTE 4'h8
`define DUMMY_Q_5BYTE 4'hA

// filler driven when the byte buffer runs dry
`define UNDERRUN_BYTE 8'hFF

`endif

//--- hw/multi_io_fast_read_engine.sv
/*
  read path of a serial flash: dual/quad output and dual/quad io fast reads,
  enhance mode, address auto-increment. the array is reached by a request
  port and a byte return stream through a two-entry buffer.
  assumes sclk, cs_n and io pins are asynchronous and much slower than
  i_core_clk; mode and busy inputs come from logic on i_core_clk.
*/
// Functional notes
// - opcode 3Bh returns data two bits per clock on lines 1 and 0
// - 3Bh inserts eight ignored dummy clocks after the 24-bit address
// - opcode BBh takes address, dummy and data two bits per clock
// - address sampled on rising clock edges, data shifted out on falling edges
// - address advances per byte from any start and wraps to zero
// - 6Bh: single-line opcode and address, eight dummies, four-line data
// - chip select high ends the read and stops data drive at once
// - EBh takes four-line address, six dummy clocks, four-line data
// - after EBh opcode, address, dummy and data phases run four bits wide
// - EBh also accepted in quad command mode with a four-line opcode
// - enhance sequence: mode byte on four lines, then four dummy clocks
// - complementary mode nibbles keep enhance mode; next frame starts at address
// - non-complementary mode byte clears enhance mode; next frame needs opcode
// - a frame holding only an all-ones byte exits enhance mode
// - EBh rejected while program, erase or status write runs
// - dummy length field selects 4, 6, 8 or 10 quad clocks; reset 6
`timescale 1ns/1ps
`include "fast_read_regs.svh"

module multi_io_fast_read_engine #(
  parameter int ADDR_W = 24
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [3:0] i_io,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe,
  input wire logic i_quad_command_mode,
  input wire logic i_quad_pin_function_enable,
  input wire logic [1:0] i_dummy_len,
  input wire logic i_write_busy,
  output logic o_mem_rd_valid,
  output logic [ADDR_W-1:0] o_mem_rd_addr,
  input wire logic i_mem_rd_ready,
  input wire logic i_mem_data_valid,
  input wire logic [7:0] i_mem_data,
  output logic o_mem_data_ready,
  output logic o_enhance_mode,
  output logic o_read_active,
  output logic o_read_rejected
);
  if (ADDR_W % 4 != 0 || ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must be a multiple of 4 between 8 and 32");
  end

  logic [5:0] pins_s;
  logic sclk_s, cs_n_s;
  logic [3:0] io_s;
  logic sclk_q, sclk_d;
  logic rise, fall;

  pin_sync2 #(.W(6), .RST_VAL(6'h02)) u_sync (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_d({i_io, i_cs_n, i_sclk}),
    .o_q(pins_s)
  );

  assign sclk_s = pins_s[0];
  assign cs_n_s = pins_s[1];
  assign io_s = pins_s[5:2];
  assign rise = sclk_s && !sclk_q;
  assign fall = !sclk_s && sclk_q;

  byte_stream_if #(.W(8)) mem_s ();
  byte_stream_if #(.W(8)) byte_s ();
  logic [1:0] buf_cnt;
  logic pop;

  fast_read_pkg::rd_state_t state_q, state_d;
  fast_read_pkg::lane_t lane_in_q, lane_in_d, lane_out_q, lane_out_d;
  logic [5:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] shift_q, shift_d, samp;
  logic [ADDR_W-1:0] faddr_q, faddr_d, maddr_q, maddr_d;
  logic [7:0] oshift_q, oshift_d, byte_in;
  logic [3:0] dummy_q, dummy_d, qio_dummy;
  logic [3:0] io_q, io_d, oe_q, oe_d;
  logic [2:0] step_in, step_out;
  logic mode_q, mode_d, enh_q, enh_d, ones_q, ones_d, new_ones;
  logic fetch_q, fetch_d, req_q, req_d, pend_q, pend_d, disc_q, disc_d;
  logic act_q, act_d, rej_q, rej_d;
  logic issue, mem_hs;

  // receive sampling by lane width
  always_comb begin
    case (lane_in_q)
      fast_read_pkg::LANE_2: begin
        samp = {shift_q[ADDR_W-3:0], io_s[1:0]};
        new_ones = &io_s[1:0];
        step_in = 3'h2;
      end
      fast_read_pkg::LANE_4: begin
        samp = {shift_q[ADDR_W-5:0], io_s[3:0]};
        new_ones = &io_s;
        step_in = 3'h4;
      end
      default: begin
        samp = {shift_q[ADDR_W-2:0], io_s[0]};
        new_ones = io_s[0];
        step_in = 3'h1;
      end
    endcase
    step_out = (lane_out_q == fast_read_pkg::LANE_4) ? 3'h4 : 3'h2;
    case (i_dummy_len)
      `DLEN_2BYTE: qio_dummy = `DUMMY_Q_2BYTE;
      `DLEN_4BYTE: qio_dummy = `DUMMY_Q_4BYTE;
      `DLEN_5BYTE: qio_dummy = `DUMMY_Q_5BYTE;
      default: qio_dummy = `DUMMY_Q_3BYTE;
    endcase
    byte_in = byte_s.valid ? byte_s.data : `UNDERRUN_BYTE;
  end

  assign pop = (state_q == fast_read_pkg::ST_DATA) && fall && (cnt_q == 6'h00) && !cs_n_s;
  assign byte_s.ready = pop;
  assign mem_s.valid = i_mem_data_valid && !disc_q;
  assign mem_s.data = i_mem_data;
  assign mem_hs = i_mem_data_valid && mem_s.ready;
  assign issue = fetch_q && !req_q && !pend_q && !disc_q && (buf_cnt < 2'h2);

  byte_buffer #(.W(8), .DEPTH(2)) u_buf (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_flush(cs_n_s),
    .in_s(mem_s),
    .out_s(byte_s),
    .o_count(buf_cnt)
  );

  // frame decode and shifting
  always_comb begin
    sclk_d = sclk_s;
    state_d = state_q;
    lane_in_d = lane_in_q;
    lane_out_d = lane_out_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    oshift_d = oshift_q;
    dummy_d = dummy_q;
    mode_d = mode_q;
    enh_d = enh_q;
    ones_d = ones_q;
    io_d = io_q;
    oe_d = oe_q;
    fetch_d = fetch_q;
    faddr_d = faddr_q;
    rej_d = 1'b0;
    if (cs_n_s) begin
      state_d = fast_read_pkg::ST_IDLE;
      oe_d = 4'h0;
      fetch_d = 1'b0;
      if (state_q == fast_read_pkg::ST_ADDR && enh_q && ones_q && cnt_q >= `OPC_BITS) begin
        enh_d = 1'b0;
      end
    end else begin
      case (state_q)
        fast_read_pkg::ST_IDLE: begin
          cnt_d = 6'h00;
          shift_d = '0;
          ones_d = 1'b1;
          mode_d = 1'b0;
          if (enh_q && i_write_busy) begin
            state_d = fast_read_pkg::ST_IGNORE;
            rej_d = 1'b1;
          end else if (enh_q) begin
            state_d = fast_read_pkg::ST_ADDR;
            lane_in_d = fast_read_pkg::LANE_4;
            lane_out_d = fast_read_pkg::LANE_4;
            mode_d = 1'b1;
            dummy_d = 4'(qio_dummy - `MODE_CLKS);
          end else begin
            state_d = fast_read_pkg::ST_OPC;
            lane_in_d = i_quad_command_mode ? fast_read_pkg::LANE_4 : fast_read_pkg::LANE_1;
          end
        end
        fast_read_pkg::ST_OPC: begin
          if (rise) begin
            shift_d = samp;
            cnt_d = 6'(cnt_q + step_in);
            if (6'(cnt_q + step_in) == `OPC_BITS) begin
              cnt_d = 6'h00;
              state_d = fast_read_pkg::ST_ADDR;
              case (samp[7:0])
                `OPC_DUAL_OUT: begin
                  lane_in_d = fast_read_pkg::LANE_1;
                  lane_out_d = fast_read_pkg::LANE_2;
                  dummy_d = `DUMMY_OUT_CLKS;
                end
                `OPC_DUAL_IO: begin
                  lane_in_d = fast_read_pkg::LANE_2;
                  lane_out_d = fast_read_pkg::LANE_2;
                  dummy_d = `DUMMY_DUAL_IO_CLKS;
                end
                `OPC_QUAD_OUT: begin
                  lane_in_d = fast_read_pkg::LANE_1;
                  lane_out_d = fast_read_pkg::LANE_4;
                  dummy_d = `DUMMY_OUT_CLKS;
                end
                `OPC_QUAD_IO: begin
                  lane_in_d = fast_read_pkg::LANE_4;
                  lane_out_d = fast_read_pkg::LANE_4;
                  mode_d = 1'b1;
                  dummy_d = 4'(qio_dummy - `MODE_CLKS);
                  if (i_write_busy) begin
                    state_d = fast_read_pkg::ST_IGNORE;
                    rej_d = 1'b1;
                  end
                end
                default: state_d = fast_read_pkg::ST_IGNORE;
              endcase
              if (i_quad_command_mode && samp[7:0] != `OPC_QUAD_IO) begin
                state_d = fast_read_pkg::ST_IGNORE;
              end
            end
          end
        end
        fast_read_pkg::ST_ADDR: begin
          if (rise) begin
            shift_d = samp;
            ones_d = ones_q && new_ones;
            cnt_d = 6'(cnt_q + step_in);
            if (6'(cnt_q + step_in) == 6'(ADDR_W)) begin
              cnt_d = 6'h00;
              faddr_d = samp;
              fetch_d = 1'b1;
              state_d = mode_q ? fast_read_pkg::ST_MODE : fast_read_pkg::ST_DUMMY;
            end
          end
        end
        fast_read_pkg::ST_MODE: begin
          if (rise) begin
            shift_d = samp;
            cnt_d = 6'(cnt_q + step_in);
            if (6'(cnt_q + step_in) == `MODE_BITS) begin
              cnt_d = 6'h00;
              enh_d = (samp[7:4] == ~samp[3:0]);
              state_d = fast_read_pkg::ST_DUMMY;
            end
          end
        end
        fast_read_pkg::ST_DUMMY: begin
          if (rise) begin
            cnt_d = 6'(cnt_q + 1'b1);
            if (6'(cnt_q + 1'b1) == 6'(dummy_q)) begin
              cnt_d = 6'h00;
              state_d = fast_read_pkg::ST_DATA;
            end
          end
        end
        fast_read_pkg::ST_DATA: begin
          if (fall) begin
            oe_d = (lane_out_q == fast_read_pkg::LANE_4) ? 4'hF : 4'h3;
            if (cnt_q == 6'h00) begin
              io_d = (lane_out_q == fast_read_pkg::LANE_4) ? byte_in[7:4] : {2'h0, byte_in[7:6]};
              oshift_d = 8'(byte_in << step_out);
              cnt_d = 6'(4'h8 - step_out);
            end else begin
              io_d = (lane_out_q == fast_read_pkg::LANE_4) ? oshift_q[7:4] : {2'h0, oshift_q[7:6]};
              oshift_d = 8'(oshift_q << step_out);
              cnt_d = 6'(cnt_q - step_out);
            end
          end
        end
        default: begin
          oe_d = 4'h0;
        end
      endcase
    end
    if (issue) begin
      faddr_d = ADDR_W'(faddr_q + 1'b1);
    end
  end

  // array fetch handshake
  always_comb begin
    req_d = req_q;
    pend_d = pend_q;
    disc_d = disc_q;
    maddr_d = maddr_q;
    if (req_q && i_mem_rd_ready) begin
      req_d = 1'b0;
      pend_d = 1'b1;
    end
    if (mem_hs) begin
      pend_d = 1'b0;
      disc_d = 1'b0;
    end
    if (cs_n_s && fetch_q) begin
      disc_d = req_q || (pend_q && !mem_hs);
    end
    if (issue) begin
      req_d = 1'b1;
      maddr_d = faddr_q;
    end
    act_d = (state_d != fast_read_pkg::ST_IDLE) && (state_d != fast_read_pkg::ST_IGNORE);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      sclk_q <= 1'b0;
      state_q <= fast_read_pkg::ST_IDLE;
      lane_in_q <= fast_read_pkg::LANE_1;
      lane_out_q <= fast_read_pkg::LANE_2;
      cnt_q <= 6'h00;
      shift_q <= '0;
      oshift_q <= 8'h00;
      dummy_q <= `DUMMY_OUT_CLKS;
      mode_q <= 1'b0;
      enh_q <= 1'b0;
      ones_q <= 1'b0;
      io_q <= 4'h0;
      oe_q <= 4'h0;
      fetch_q <= 1'b0;
      faddr_q <= '0;
      maddr_q <= '0;
      req_q <= 1'b0;
      pend_q <= 1'b0;
      disc_q <= 1'b0;
      act_q <= 1'b0;
      rej_q <= 1'b0;
    end else begin
      sclk_q <= sclk_d;
      state_q <= state_d;
      lane_in_q <= lane_in_d;
      lane_out_q <= lane_out_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      oshift_q <= oshift_d;
      dummy_q <= dummy_d;
      mode_q <= mode_d;
      enh_q <= enh_d;
      ones_q <= ones_d;
      io_q <= io_d;
      oe_q <= oe_d;
      fetch_q <= fetch_d;
      faddr_q <= faddr_d;
      maddr_q <= maddr_d;
      req_q <= req_d;
      pend_q <= pend_d;
      disc_q <= disc_d;
      act_q <= act_d;
      rej_q <= rej_d;
    end
  end

  assign o_io = io_q;
  assign o_io_oe = oe_q;
  assign o_mem_rd_valid = req_q;
  assign o_mem_rd_addr = maddr_q;
  assign o_mem_data_ready = mem_s.ready;
  assign o_enhance_mode = enh_q;
  assign o_read_active = act_q;
  assign o_read_rejected = rej_q;

  // checks
  logic opc_done;
  assign opc_done = (state_q == fast_read_pkg::ST_OPC) && rise && !cs_n_s && (6'(cnt_q + step_in) == `OPC_BITS);

  chk_cs_stop: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    cs_n_s |=> (o_io_oe == 4'h0) && !o_read_active)
    else $error("data drive not stopped after chip select rose");
  chk_dual_out_setup: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    opc_done && !i_quad_command_mode && samp[7:0] == `OPC_DUAL_OUT
    |=> dummy_q == 4'h8 && lane_out_q == fast_read_pkg::LANE_2 && lane_in_q == fast_read_pkg::LANE_1)
    else $error("dual output read set up wrongly");
  chk_quad_out_setup: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    opc_done && !i_quad_command_mode && samp[7:0] == `OPC_QUAD_OUT
    |=> dummy_q == 4'h8 && lane_out_q == fast_read_pkg::LANE_4 && lane_in_q == fast_read_pkg::LANE_1)
    else $error("quad output read set up wrongly");
  chk_qio_reject: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    opc_done && i_write_busy && samp[7:0] == `OPC_QUAD_IO
    |=> o_read_rejected && state_q == fast_read_pkg::ST_IGNORE ##1 !o_read_rejected)
    else $error("quad io read not rejected while busy");
  chk_qio_dummy_len: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    opc_done && !i_write_busy && samp[7:0] == `OPC_QUAD_IO && i_dummy_len == 2'h0
    |=> dummy_q == 4'h4 && mode_q && lane_in_q == fast_read_pkg::LANE_4)
    else $error("quad io dummy count wrong for default length");
  chk_enh_keep: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    state_q == fast_read_pkg::ST_MODE && rise && !cs_n_s && cnt_q == 6'h04 && samp[7:4] == ~samp[3:0]
    |=> o_enhance_mode)
    else $error("complementary mode byte did not keep enhance mode");
  chk_enh_clear: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    state_q == fast_read_pkg::ST_MODE && rise && !cs_n_s && cnt_q == 6'h04 && samp[7:4] != ~samp[3:0]
    |=> !o_enhance_mode)
    else $error("plain mode byte did not clear enhance mode");
  chk_enh_frame: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    state_q == fast_read_pkg::ST_IDLE && !cs_n_s && enh_q && !i_write_busy
    |=> state_q == fast_read_pkg::ST_ADDR && lane_in_q == fast_read_pkg::LANE_4)
    else $error("enhance frame did not start at the address");
  chk_addr_step: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    issue |=> o_mem_rd_valid && o_mem_rd_addr == $past(faddr_q) && faddr_q == ADDR_W'($past(faddr_q) + 1'b1))
    else $error("read address did not advance by one");
  chk_fall_only: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    state_q == fast_read_pkg::ST_DATA && !fall && !cs_n_s |=> $stable(o_io))
    else $error("data changed away from a falling clock edge");

  cov_dual_out: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
    opc_done && samp[7:0] == `OPC_DUAL_OUT ##[1:1000] pop);
  cov_enh_enter: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $rose(enh_q));
  cov_enh_exit: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $fell(enh_q) && state_q == fast_read_pkg::ST_ADDR);
  cov_reject: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_read_rejected);
endmodule : multi_io_fast_read_engine

//--- hw/pin_sync2.sv
/*
  two-flop synchroniser for a group of pins.
  assumes the pins are asynchronous to i_core_clk.
*/
`timescale 1ns/1ps

module pin_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = i_d;
    sync_d = meta_q;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_q = sync_q;
endmodule : pin_sync2

//--- test/spi_host_model.sv
/*
  host side of the serial link: clock, select and io drive tasks.
  assumes the bench resolves the io wires and feeds them back on i_io.
*/
`timescale 1ns/1ps

module spi_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe,
  input wire logic [3:0] i_io
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h0;
    o_io_oe = 4'h0;
  end

  task automatic pulse();
    #200 o_sclk = 1'b1;
    #200 o_sclk = 1'b0;
  endtask : pulse

  task automatic sel(input logic v);
    o_io_oe = 4'h0;
    #400 o_cs_n = v;
    #400;
  endtask : sel

  // w bits a clock, msb first; unused lines held high
  task automatic send(input logic [31:0] v, input int n, input int w);
    logic [31:0] t;
    for (int k = 0; k < n; k++) begin
      t = v >> (w * (n - 1 - k));
      o_io_oe = 4'hF;
      o_io = (w == 4) ? t[3:0] : (w == 2) ? {2'b11, t[1:0]} : {3'b111, t[0]};
      pulse();
    end
  endtask : send

  // junk on line 0 during dummies, released for the last one
  task automatic idle(input int n);
    for (int k = 0; k < n; k++) begin
      o_io = 4'($urandom);
      o_io_oe = (k < n - 1) ? 4'h1 : 4'h0;
      pulse();
    end
  endtask : idle

  task automatic recv(input int n, input int w, output logic [7:0] v);
    o_io_oe = 4'h0;
    v = 8'h00;
    for (int k = 0; k < n; k++) begin
      #200 o_sclk = 1'b1;
      #100 v = (v << w) | {4'h0, i_io & ((w == 4) ? 4'hF : 4'h3)};
      #100 o_sclk = 1'b0;
    end
  endtask : recv
endmodule : spi_host_model

//--- test/test_multi_io_fast_read_engine.sv
/*
  self-checking bench of the fast read engine with a random-latency array.
  assumes the host model owns the link pins; all io lines are pulled high.
*/
`timescale 1ns/1ps

module test_multi_io_fast_read_engine;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic qcm = 1'b0;
  logic pfe;
  logic busy = 1'b0;
  logic [1:0] dlen = 2'h0;
  logic rd_rdy;
  logic dat_vld;
  logic pend = 1'b0;
  logic saw_full = 1'b0;
  logic [7:0] dat;
  int rej_cnt = 0;
  logic [23:0] paddr = 24'h0000;
  logic sclk, cs_n, rd_vld, dat_rdy, enh, act, rej;
  logic [3:0] h_io, h_oe, d_io, d_oe, io_w;
  logic [23:0] rd_addr;
  int dq[4] = '{6, 4, 8, 10};
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;

  assign io_w = (h_oe & h_io) | (~h_oe & d_oe & d_io) | (~h_oe & ~d_oe);
  always #25 clk = ~clk;

  spi_host_model i_spi_host_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(h_io), .o_io_oe(h_oe), .i_io(io_w));
  multi_io_fast_read_engine i_multi_io_fast_read_engine (.i_core_clk(clk), .i_reset_n(rst_n), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_io(io_w), .o_io(d_io), .o_io_oe(d_oe), .i_quad_command_mode(qcm),
    .i_quad_pin_function_enable(pfe), .i_dummy_len(dlen), .i_write_busy(busy), .o_mem_rd_valid(rd_vld),
    .o_mem_rd_addr(rd_addr), .i_mem_rd_ready(rd_rdy), .i_mem_data_valid(dat_vld), .i_mem_data(dat),
    .o_mem_data_ready(dat_rdy), .o_enhance_mode(enh), .o_read_active(act), .o_read_rejected(rej));

  function automatic logic [7:0] mem_byte(input logic [23:0] a);
    return a[7:0] ^ a[23:16] ^ 8'h3C;
  endfunction : mem_byte

  task automatic report_and_stop();
    if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // array side: one request outstanding, random latency on both handshakes
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rej === 1'b1) rej_cnt <= rej_cnt + 1;
    if (dat_rdy === 1'b0 && act === 1'b1) saw_full <= 1'b1;
    if (rd_vld === 1'b1 && rd_rdy) begin
      pend <= 1'b1;
      paddr <= rd_addr;
    end else if (dat_vld && dat_rdy === 1'b1) pend <= 1'b0;
    if (cyc == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end

  always @(negedge clk) begin
    rd_rdy <= !pend && 1'($urandom);
    dat_vld <= pend && (dat_vld || 1'($urandom));
    dat <= mem_byte(paddr);
  end

  task automatic rd(input logic [7:0] opc, input int aw, input logic [23:0] a, input int dm, input int dw,
                    input int nb, input logic [7:0] mode, input bit no_opc);
    logic [7:0] v;
    i_spi_host_model.sel(1'b0);
    if (!no_opc) i_spi_host_model.send({24'h0, opc}, qcm ? 2 : 8, qcm ? 4 : 1);
    i_spi_host_model.send({8'h00, a}, 24 / aw, aw);
    if (aw == 4) i_spi_host_model.send({24'h0, mode}, 2, 4);
    i_spi_host_model.idle(dm);
    for (int b = 0; b < nb; b++) begin
      i_spi_host_model.recv(8 / dw, dw, v);
      chk("data", mem_byte(a + 24'(b)), v);
    end
    i_spi_host_model.sel(1'b1);
    chk("oe_after_cs", 8'h00, {4'h0, d_oe});
  endtask : rd

  initial begin
    logic [7:0] m;
    void'($urandom(32'hc30aee15));
    pfe = 1'($urandom);
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    rd(8'h3B, 1, 24'($urandom), 8, 2, 3, 8'h00, 1'b0);
    rd(8'hBB, 2, 24'($urandom), 4, 2, 3, 8'h00, 1'b0);
    rd(8'h6B, 1, 24'($urandom), 8, 4, 3, 8'h00, 1'b0);
    for (int d = 0; d < 4; d++) begin
      @(negedge clk) dlen = 2'(d);
      rd(8'hEB, 4, 24'($urandom), dq[d] - 2, 4, 2, 8'h00, 1'b0);
    end
    @(negedge clk) dlen = 2'h0;
    rd(8'hEB, 4, 24'hFF_FFFE, 4, 4, 4, 8'h00, 1'b0);
    m = 8'($urandom);
    rd(8'hEB, 4, 24'($urandom), 4, 4, 2, {~m[3:0], m[3:0]}, 1'b0);
    chk("enhance_on", 8'h01, {7'h0, enh});
    rd(8'hEB, 4, 24'($urandom), 4, 4, 2, 8'hFF, 1'b1);
    chk("enhance_off", 8'h00, {7'h0, enh});
    rd(8'h6B, 1, 24'($urandom), 8, 4, 1, 8'h00, 1'b0);
    rd(8'hEB, 4, 24'($urandom), 4, 4, 1, 8'h5A, 1'b0);
    @(negedge clk) busy = 1'b1;
    i_spi_host_model.sel(1'b0);
    i_spi_host_model.send(32'h0000_0000, 2, 4);
    chk("active_enh_busy", 8'h00, {7'h0, act});
    i_spi_host_model.sel(1'b1);
    @(negedge clk) busy = 1'b0;
    chk("enhance_kept", 8'h01, {7'h0, enh});
    i_spi_host_model.sel(1'b0);
    i_spi_host_model.send(32'h0000_00FF, 2, 4);
    i_spi_host_model.sel(1'b1);
    chk("enhance_exit", 8'h00, {7'h0, enh});
    @(negedge clk) qcm = 1'b1;
    pfe = 1'($urandom);
    rd(8'hEB, 4, 24'($urandom), 4, 4, 2, 8'h00, 1'b0);
    i_spi_host_model.sel(1'b0);
    i_spi_host_model.send(32'h0000_006B, 2, 4);
    chk("qcm_refuse", 8'h00, {7'h0, act});
    i_spi_host_model.sel(1'b1);
    @(negedge clk) qcm = 1'b0;
    i_spi_host_model.sel(1'b0);
    i_spi_host_model.send(32'h0000_00EB, 8, 1);
    i_spi_host_model.send(32'($urandom) & 32'hFFFF_FF00, 8, 4);
    i_spi_host_model.idle(4);
    i_spi_host_model.recv(1, 4, m);
    i_spi_host_model.sel(1'b1);
    chk("oe_abort", 8'h00, {4'h0, d_oe});
    @(negedge clk) busy = 1'b1;
    i_spi_host_model.sel(1'b0);
    i_spi_host_model.send(32'h0000_00EB, 8, 1);
    i_spi_host_model.send(32'h0000_0000, 8, 4);
    chk("rejected", 8'h02, 8'(rej_cnt));
    chk("active", 8'h00, {7'h0, act});
    i_spi_host_model.sel(1'b1);
    @(negedge clk) busy = 1'b0;
    chk("buffer_full_seen", 8'h01, {7'h0, saw_full});
    report_and_stop();
  end
endmodule : test_multi_io_fast_read_engine
